// >>> inc/cifm_pkg.sv
// Constants, codes and register map of the contact input function mapper
package cifm_pkg;
    localparam int NUM_IN = 11;
    localparam int CODE_W = 5;
    localparam int SP_W = 8;
    localparam int INT_W = 16;
    localparam int TOT_W = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
    localparam logic [CODE_W-1:0] CODE_GRID1 = 5'h02;
    localparam logic [CODE_W-1:0] CODE_POOL = 5'h03;
    localparam logic [CODE_W-1:0] CODE_SOLAR = 5'h04;
    localparam logic [CODE_W-1:0] CODE_CHANGE = 5'h05;
    localparam logic [CODE_W-1:0] CODE_BOOST = 5'h06;
    localparam logic [CODE_W-1:0] CODE_METER1 = 5'h07;
    localparam logic [CODE_W-1:0] CODE_ROOM1 = 5'h08;
    localparam logic [CODE_W-1:0] CODE_ROOM2 = 5'h09;
    localparam logic [CODE_W-1:0] CODE_FHEAT = 5'h0A;
    localparam logic [CODE_W-1:0] CODE_FCOOL = 5'h0B;
    localparam logic [CODE_W-1:0] CODE_METER2 = 5'h0C;
    localparam logic [CODE_W-1:0] CODE_ECO12 = 5'h0D;
    localparam logic [CODE_W-1:0] CODE_ECO1 = 5'h0E;
    localparam logic [CODE_W-1:0] CODE_ECO2 = 5'h0F;
    localparam logic [CODE_W-1:0] CODE_FOFF = 5'h10;
    localparam logic [CODE_W-1:0] CODE_GRID2 = 5'h11;
    localparam logic [CODE_W-1:0] CODE_MAX = 5'h11;

    // Input 1 sits in the low field
    localparam logic [NUM_IN*CODE_W-1:0] CODE_RESET = {5'h00, 5'h00, 5'h09, 5'h0C, 5'h07, 5'h06,
                                                       5'h02, 5'h04, 5'h00, 5'h0D, 5'h08};

    localparam logic [ADDR_W-1:0] REG_CODE_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h40;
    localparam logic [ADDR_W-1:0] REG_SETPT = 8'h44;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h48;
    localparam logic [ADDR_W-1:0] REG_E1_INT = 8'h4C;
    localparam logic [ADDR_W-1:0] REG_E1_TOT = 8'h50;
    localparam logic [ADDR_W-1:0] REG_E2_INT = 8'h54;
    localparam logic [ADDR_W-1:0] REG_E2_TOT = 8'h58;

    localparam int CTRL_W = 7;
    localparam int CTRL_POOL = 0;
    localparam int CTRL_HW = 1;
    localparam int CTRL_HEAT = 2;
    localparam int CTRL_ROOM1 = 3;
    localparam int CTRL_ROOM2 = 4;
    localparam int CTRL_CIRC1 = 5;
    localparam int CTRL_CIRC2 = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h64;

    localparam int SP_C1_LSB = 0;
    localparam int SP_C2_LSB = 8;
    localparam int SP_OFF_LSB = 16;
    localparam logic [3*SP_W-1:0] SETPT_RESET = 24'h052323;

    localparam int STATUS_LVL_LSB = 16;

    localparam int DEBOUNCE_MS = 20;
    localparam int CLK_MHZ = 100;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
endpackage

// >>> design/cifm_debounce.sv
// Two-stage synchroniser and bounce filter for one contact
`timescale 1ns/1ps
module cifm_debounce #(
    parameter int DEB_CYCLES = cifm_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic raw_in,
    output logic level_out
);
    localparam int CNT_W = (DEB_CYCLES > 1) ? $clog2(DEB_CYCLES) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DEB_CYCLES - 1);

    if (DEB_CYCLES < 1) begin : g_bad
        $error("cifm_debounce: DEB_CYCLES must be at least 1");
    end

    logic sync_a;
    logic sync_b;
    logic [CNT_W-1:0] cnt;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // R22 - stable window filter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt <= '0;
            level_out <= 1'b0;
        end else if (sync_b == level_out) begin
            cnt <= '0;
        end else if (cnt == LAST) begin
            cnt <= '0;
            level_out <= sync_b;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    property p_filter;
        @(posedge clk_in) disable iff (!rst_n_in)
        (level_out != $past(level_out)) |-> ($past(cnt) == LAST && $past(sync_b) == level_out);
    endproperty
    a_filter: assert property (p_filter) else $error("level changed before stable window"); // R22
endmodule

// >>> design/cifm_mapper.sv
// Contact input function mapper: filtering, code decode, control state and registers
// Notes on behaviour
// R1 - Each input carries a code zero to seventeen that alone selects its function.
// R2 - Grid-limit code active stops or cuts heat pump and auxiliary heater.
// R3 - Code 02 input is first grid digital input of the four-mode pair.
// R4 - Code 17 input is second grid digital input of the four-mode pair.
// R5 - Pool code: closed switches pool on with demand, open switches off.
// R6 - Master controller can also switch pool operation on and off.
// R7 - Solar code: closed turns solar pump on, open turns it off.
// R8 - Changeover code: closed heating, open cooling; master can also change mode.
// R9 - Boost code trigger requests immediate tank reheat and switches hot water on.
// R10 - Meter codes count energy pulses into interval and total records.
// R11 - Room codes: closed thermostat on with demand, open thermostat off.
// R12 - Master controller room settings can also switch each thermostat.
// R13 - Forced-heating code: closed forces heating, open does nothing.
// R14 - Forced-cooling code: closed forces cooling, open does nothing.
// R15 - Dual eco code: closed enables offset on both circuits, open disables.
// R16 - Circuit one eco code enables offset on circuit one only.
// R17 - Circuit two eco code enables offset on circuit two only.
// R18 - Enabled offset lowers setpoint in heating, raises it in cooling.
// R19 - Force-off code closed forces off both circuits, hot water and pool.
// R20 - Software never assigns changeover, forced heating and forced cooling together.
// R21 - No-function code input affects no control function.
// R22 - Inputs are synchronised and debounced so each change acts once.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module cifm_mapper #(
    parameter int DEB_CYCLES = cifm_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [cifm_pkg::NUM_IN-1:0] contact_in,
    input wire logic [cifm_pkg::ADDR_W-1:0] addr_in,
    input wire logic [cifm_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [cifm_pkg::DATA_W-1:0] rdata_out,
    output logic grid_limit_out,
    output logic [1:0] grid_signal_mode_out,
    output logic pool_loop_on_out,
    output logic pool_loop_demand_out,
    output logic solar_pump_on_out,
    output logic heat_mode_out,
    output logic hot_water_tank_on_out,
    output logic hot_water_tank_boost_out,
    output logic [1:0] room_on_out,
    output logic [1:0] setpoint_offset_en_out,
    output logic [1:0] circuit_on_out,
    output logic force_off_out,
    output logic [cifm_pkg::SP_W-1:0] setpoint_c1_out,
    output logic [cifm_pkg::SP_W-1:0] setpoint_c2_out
);
    localparam int N = cifm_pkg::NUM_IN;
    localparam int CW = cifm_pkg::CODE_W;
    localparam int SW = cifm_pkg::SP_W;
    localparam int IW = cifm_pkg::INT_W;
    localparam int TW = cifm_pkg::TOT_W;

    if (DEB_CYCLES < 1) begin : g_bad
        $error("cifm_mapper: DEB_CYCLES must be at least 1");
    end

    function automatic logic [N-1:0] code_mask(input logic [N*CW-1:0] codes, input logic [CW-1:0] c);
        logic [N-1:0] m;
        m = '0;
        for (int i = 0; i < N; i++) begin
            m[i] = (codes[i*CW +: CW] == c);
        end
        return m;
    endfunction

    function automatic logic codes_legal(input logic [N*CW-1:0] codes);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < N; i++) begin
            ok = ok && (codes[i*CW +: CW] <= cifm_pkg::CODE_MAX);
        end
        return ok;
    endfunction

    // Saturates instead of wrapping so a large offset cannot flip the setpoint
    function automatic logic [SW-1:0] adjust(input logic [SW-1:0] base, input logic [SW-1:0] off,
                                             input logic en, input logic heat);
        logic [SW:0] sum;
        sum = {1'b0, base} + {1'b0, off};
        if (!en) begin
            return base;
        end else if (heat) begin
            return (base > off) ? (base - off) : '0;
        end else begin
            return sum[SW] ? {SW{1'b1}} : sum[SW-1:0];
        end
    endfunction

    function automatic logic [IW-1:0] next_interval(input logic [IW-1:0] cur, input logic clr,
                                                    input logic pulse);
        if (clr) begin
            return {{(IW-1){1'b0}}, pulse};
        end
        return cur + {{(IW-1){1'b0}}, pulse};
    endfunction

    logic [N-1:0] lvl;
    logic [N-1:0] lvl_prev;
    logic [N*CW-1:0] codes;
    logic [cifm_pkg::CTRL_W-1:0] ctrl;
    logic [3*SW-1:0] setpt;
    logic [IW-1:0] e1_int;
    logic [IW-1:0] e2_int;
    logic [TW-1:0] e1_tot;
    logic [TW-1:0] e2_tot;

    // R22 - per-input filter
    for (genvar g = 0; g < N; g++) begin : g_deb
        cifm_debounce #(
            .DEB_CYCLES(DEB_CYCLES)
        ) u_deb (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .raw_in(contact_in[g]),
            .level_out(lvl[g])
        );
    end

    wire [N-1:0] rise = lvl & ~lvl_prev;
    wire [N-1:0] fall = ~lvl & lvl_prev;

    // R1 - code alone picks function
    wire [N-1:0] m_grid1 = code_mask(codes, cifm_pkg::CODE_GRID1);
    wire [N-1:0] m_grid2 = code_mask(codes, cifm_pkg::CODE_GRID2);
    wire [N-1:0] m_pool = code_mask(codes, cifm_pkg::CODE_POOL);
    wire [N-1:0] m_solar = code_mask(codes, cifm_pkg::CODE_SOLAR);
    wire [N-1:0] m_change = code_mask(codes, cifm_pkg::CODE_CHANGE);
    wire [N-1:0] m_boost = code_mask(codes, cifm_pkg::CODE_BOOST);
    wire [N-1:0] m_meter1 = code_mask(codes, cifm_pkg::CODE_METER1);
    wire [N-1:0] m_meter2 = code_mask(codes, cifm_pkg::CODE_METER2);
    wire [N-1:0] m_room1 = code_mask(codes, cifm_pkg::CODE_ROOM1);
    wire [N-1:0] m_room2 = code_mask(codes, cifm_pkg::CODE_ROOM2);
    wire [N-1:0] m_fheat = code_mask(codes, cifm_pkg::CODE_FHEAT);
    wire [N-1:0] m_fcool = code_mask(codes, cifm_pkg::CODE_FCOOL);
    wire [N-1:0] m_eco12 = code_mask(codes, cifm_pkg::CODE_ECO12);
    wire [N-1:0] m_eco1 = code_mask(codes, cifm_pkg::CODE_ECO1);
    wire [N-1:0] m_eco2 = code_mask(codes, cifm_pkg::CODE_ECO2);
    wire [N-1:0] m_foff = code_mask(codes, cifm_pkg::CODE_FOFF);

    // R21 - unused code has no mask
    wire act_grid1 = |(lvl & m_grid1);
    wire act_grid2 = |(lvl & m_grid2);
    wire act_solar = |(lvl & m_solar);
    wire act_fheat = |(lvl & m_fheat);
    wire act_fcool = |(lvl & m_fcool);
    wire act_foff = |(lvl & m_foff);
    wire act_eco1 = |(lvl & (m_eco12 | m_eco1));
    wire act_eco2 = |(lvl & (m_eco12 | m_eco2));
    wire rise_pool = |(rise & m_pool);
    wire fall_pool = |(fall & m_pool);
    wire rise_change = |(rise & m_change);
    wire fall_change = |(fall & m_change);
    wire rise_boost = |(rise & m_boost);
    wire rise_room1 = |(rise & m_room1);
    wire fall_room1 = |(fall & m_room1);
    wire rise_room2 = |(rise & m_room2);
    wire fall_room2 = |(fall & m_room2);
    wire pulse1 = |(rise & m_meter1);
    wire pulse2 = |(rise & m_meter2);

    wire addr_is_code = (addr_in[1:0] == 2'b00) && (addr_in >= cifm_pkg::REG_CODE_BASE)
                        && (addr_in < cifm_pkg::REG_CODE_BASE + cifm_pkg::ADDR_W'(4 * N));
    wire [cifm_pkg::ADDR_W-1:0] code_off = addr_in - cifm_pkg::REG_CODE_BASE;
    wire [cifm_pkg::ADDR_W-3:0] code_idx = code_off[cifm_pkg::ADDR_W-1:2];
    wire code_ok = wdata_in[CW-1:0] <= cifm_pkg::CODE_MAX;
    wire wr_ctrl = wr_in && (addr_in == cifm_pkg::REG_CTRL);
    wire wr_setpt = wr_in && (addr_in == cifm_pkg::REG_SETPT);
    wire clr_e1 = wr_in && (addr_in == cifm_pkg::REG_E1_INT);
    wire clr_e2 = wr_in && (addr_in == cifm_pkg::REG_E2_INT);

    wire [SW-1:0] sp_c1 = setpt[cifm_pkg::SP_C1_LSB +: SW];
    wire [SW-1:0] sp_c2 = setpt[cifm_pkg::SP_C2_LSB +: SW];
    wire [SW-1:0] sp_off = setpt[cifm_pkg::SP_OFF_LSB +: SW];

    // Contact events beat a same-cycle master write
    wire [cifm_pkg::CTRL_W-1:0] ctrl_wr = wr_ctrl ? wdata_in[cifm_pkg::CTRL_W-1:0] : ctrl;
    // R5 - pool follows contact edges
    // R6 - master write when no edge
    wire next_pool = rise_pool ? 1'b1 : (fall_pool ? 1'b0 : ctrl_wr[cifm_pkg::CTRL_POOL]);
    // R9 - boost switches hot water on
    wire next_hw = rise_boost ? 1'b1 : ctrl_wr[cifm_pkg::CTRL_HW];
    // R13 - forced heating wins
    // R14 - forced cooling next
    // R8 - changeover edges, then master
    wire next_heat = act_fheat ? 1'b1 : (act_fcool ? 1'b0 :
                     (rise_change ? 1'b1 : (fall_change ? 1'b0 : ctrl_wr[cifm_pkg::CTRL_HEAT])));
    // R11 - room thermostat follows contact
    // R12 - master room switch otherwise
    wire next_room1 = rise_room1 ? 1'b1 : (fall_room1 ? 1'b0 : ctrl_wr[cifm_pkg::CTRL_ROOM1]);
    wire next_room2 = rise_room2 ? 1'b1 : (fall_room2 ? 1'b0 : ctrl_wr[cifm_pkg::CTRL_ROOM2]);
    wire [cifm_pkg::CTRL_W-1:0] next_ctrl = {ctrl_wr[cifm_pkg::CTRL_CIRC2], ctrl_wr[cifm_pkg::CTRL_CIRC1],
                                             next_room2, next_room1, next_heat, next_hw, next_pool};

    // Bit 15 spare so the levels start at their own half-word
    wire [cifm_pkg::DATA_W-1:0] status_word = {5'h00, lvl, 1'b0, force_off_out, circuit_on_out,
                                               setpoint_offset_en_out, room_on_out, hot_water_tank_on_out,
                                               heat_mode_out, solar_pump_on_out, pool_loop_demand_out,
                                               pool_loop_on_out, grid_limit_out, grid_signal_mode_out};
    wire [cifm_pkg::DATA_W-1:0] code_word = {{(cifm_pkg::DATA_W-CW){1'b0}}, codes[code_idx*CW +: CW]};
    wire [cifm_pkg::DATA_W-1:0] read_value =
        addr_is_code ? code_word :
        (addr_in == cifm_pkg::REG_CTRL) ? {{(cifm_pkg::DATA_W-cifm_pkg::CTRL_W){1'b0}}, ctrl} :
        (addr_in == cifm_pkg::REG_SETPT) ? {8'h00, setpt} :
        (addr_in == cifm_pkg::REG_STATUS) ? status_word :
        (addr_in == cifm_pkg::REG_E1_INT) ? {16'h0000, e1_int} :
        (addr_in == cifm_pkg::REG_E1_TOT) ? e1_tot :
        (addr_in == cifm_pkg::REG_E2_INT) ? {16'h0000, e2_int} :
        (addr_in == cifm_pkg::REG_E2_TOT) ? e2_tot : '0;

    // R1 - out-of-range codes are dropped
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            codes <= cifm_pkg::CODE_RESET;
        end else if (wr_in && addr_is_code && code_ok) begin
            codes[code_idx*CW +: CW] <= wdata_in[CW-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl <= cifm_pkg::CTRL_RESET;
            setpt <= cifm_pkg::SETPT_RESET;
            lvl_prev <= '0;
            rdata_out <= '0;
        end else begin
            ctrl <= next_ctrl;
            setpt <= wr_setpt ? wdata_in[3*SW-1:0] : setpt;
            lvl_prev <= lvl;
            rdata_out <= rd_in ? read_value : '0;
        end
    end

    // R10 - pulse counting, pulse beats clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            e1_int <= '0;
            e2_int <= '0;
            e1_tot <= '0;
            e2_tot <= '0;
        end else begin
            e1_int <= next_interval(e1_int, clr_e1, pulse1);
            e2_int <= next_interval(e2_int, clr_e2, pulse2);
            e1_tot <= e1_tot + {{(TW-1){1'b0}}, pulse1};
            e2_tot <= e2_tot + {{(TW-1){1'b0}}, pulse2};
        end
    end

    // R18 - offset applied to setpoints
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            setpoint_c1_out <= '0;
            setpoint_c2_out <= '0;
            hot_water_tank_boost_out <= 1'b0;
        end else begin
            setpoint_c1_out <= adjust(sp_c1, sp_off, act_eco1, heat_mode_out);
            setpoint_c2_out <= adjust(sp_c2, sp_off, act_eco2, heat_mode_out);
            hot_water_tank_boost_out <= rise_boost;
        end
    end

    // R2 - grid limit request
    assign grid_limit_out = act_grid1;
    // R3 - first grid input in bit 0
    // R4 - second grid input in bit 1
    assign grid_signal_mode_out = {act_grid2, act_grid1};
    // R7 - solar pump follows level
    assign solar_pump_on_out = act_solar;
    // R19 - force off gates outputs
    assign force_off_out = act_foff;
    assign pool_loop_on_out = ctrl[cifm_pkg::CTRL_POOL] & ~act_foff;
    assign pool_loop_demand_out = ctrl[cifm_pkg::CTRL_POOL] & ~act_foff;
    assign hot_water_tank_on_out = ctrl[cifm_pkg::CTRL_HW] & ~act_foff;
    assign circuit_on_out = {ctrl[cifm_pkg::CTRL_CIRC2], ctrl[cifm_pkg::CTRL_CIRC1]} & {2{~act_foff}};
    assign heat_mode_out = ctrl[cifm_pkg::CTRL_HEAT];
    assign room_on_out = {ctrl[cifm_pkg::CTRL_ROOM2], ctrl[cifm_pkg::CTRL_ROOM1]};
    // R15 - dual eco code both bits
    // R16 - eco one on bit 0
    // R17 - eco two on bit 1
    assign setpoint_offset_en_out = {act_eco2, act_eco1};

    property p_codes;
        @(posedge clk_in) disable iff (!rst_n_in) codes_legal(codes);
    endproperty
    a_codes: assert property (p_codes) else $error("code above seventeen stored"); // R1

    property p_pool;
        @(posedge clk_in) disable iff (!rst_n_in)
        (rise_pool && !act_foff) |=> (pool_loop_on_out || force_off_out) ##0 $past(lvl & m_pool) != '0;
    endproperty
    a_pool: assert property (p_pool) else $error("pool not on after contact close"); // R5

    property p_pool_off;
        @(posedge clk_in) disable iff (!rst_n_in) (fall_pool && !rise_pool) |=> !pool_loop_demand_out;
    endproperty
    a_pool_off: assert property (p_pool_off) else $error("pool demand kept after open"); // R5

    property p_boost;
        @(posedge clk_in) disable iff (!rst_n_in)
        (rise_boost && !act_foff) |=> (hot_water_tank_boost_out && ctrl[cifm_pkg::CTRL_HW]) ##1 !hot_water_tank_boost_out;
    endproperty
    a_boost: assert property (p_boost) else $error("boost not a single pulse with hot water on"); // R9

    property p_meter;
        @(posedge clk_in) disable iff (!rst_n_in) pulse1 |=> e1_tot == $past(e1_tot) + 32'h00000001;
    endproperty
    a_meter: assert property (p_meter) else $error("meter pulse not counted"); // R10

    property p_room;
        @(posedge clk_in) disable iff (!rst_n_in) (rise_room1 ##1 !fall_room1) |-> room_on_out[0];
    endproperty
    a_room: assert property (p_room) else $error("room thermostat not on after close"); // R11

    property p_fheat;
        @(posedge clk_in) disable iff (!rst_n_in) act_fheat[*2] |-> heat_mode_out;
    endproperty
    a_fheat: assert property (p_fheat) else $error("forced heating not held"); // R13

    property p_fcool;
        @(posedge clk_in) disable iff (!rst_n_in) (act_fcool && !act_fheat) |=> !heat_mode_out;
    endproperty
    a_fcool: assert property (p_fcool) else $error("forced cooling not applied"); // R14

    property p_eco;
        @(posedge clk_in) disable iff (!rst_n_in)
        (act_eco1 && heat_mode_out && sp_off != '0 && sp_c1 != '0) |=> setpoint_c1_out < $past(sp_c1);
    endproperty
    a_eco: assert property (p_eco) else $error("heating setpoint not lowered"); // R18

    property p_foff;
        @(posedge clk_in) disable iff (!rst_n_in)
        force_off_out |-> (circuit_on_out == 2'b00 && !hot_water_tank_on_out && !pool_loop_demand_out);
    endproperty
    a_foff: assert property (p_foff) else $error("force off left a function running"); // R19
endmodule

// >>> tb/cifm_contact_model.sv
// Contact bank model: one dry contact per input, with injectable bounce
`timescale 1ns/1ps
module cifm_contact_model (
    input wire logic clk_in,
    input wire logic [10:0] closed_in,
    input wire logic [10:0] glitch_in,
    output logic [10:0] contact_out
);
    initial contact_out = 11'h000;
    // Bounce lasts as long as glitch_in is held; one cycle is below the bench's four-cycle filter window
    always @(posedge clk_in) begin
        contact_out <= closed_in ^ glitch_in;
    end
endmodule

// >>> tb/cifm_mapper_tb_top.sv
// Self-checking bench for the contact input function mapper
`timescale 1ns/1ps
module cifm_mapper_tb_top;
    localparam logic [14:0] EXP_C [18] = '{15'h3040, 15'h3040, 15'h3045, 15'h3058, 15'h3060, 15'h3040, 15'h30C0,
        15'h3040, 15'h3140, 15'h3240, 15'h3040, 15'h3000, 15'h3040, 15'h3C40, 15'h3440, 15'h3840, 15'h4040,
        15'h3042};
    localparam logic [4:0] DEF_CODE [11] = '{5'h08, 5'h0D, 5'h00, 5'h04, 5'h02, 5'h06, 5'h07, 5'h0C, 5'h09,
        5'h00, 5'h00};
    logic clk_in, rst_n_in, wr_in, rd_in, heat_mode, boost;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out;
    logic [10:0] closed, glitch, contact;
    logic [1:0] circ_on;
    logic [7:0] sp1, sp2;
    int err_total, n_checks, cyc, boost_seen;

    cifm_contact_model i_cifm_contact_model (.clk_in(clk_in), .closed_in(closed), .glitch_in(glitch),
        .contact_out(contact));
    cifm_mapper #(.DEB_CYCLES(4)) i_cifm_mapper (.clk_in(clk_in), .rst_n_in(rst_n_in), .contact_in(contact),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .grid_limit_out(), .grid_signal_mode_out(), .pool_loop_on_out(), .pool_loop_demand_out(),
        .solar_pump_on_out(), .heat_mode_out(heat_mode), .hot_water_tank_on_out(),
        .hot_water_tank_boost_out(boost), .room_on_out(), .setpoint_offset_en_out(), .circuit_on_out(circ_on),
        .force_off_out(), .setpoint_c1_out(sp1), .setpoint_c2_out(sp2));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask, input string name);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(name, exp & mask, rdata_out & mask);
    endtask

    // Wait covers sync, filter, edge state and setpoint stages
    task automatic set3(input logic v);
        @(posedge clk_in);
        closed[2] <= v;
        repeat (12) @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (boost === 1'b1) begin
            boost_seen++;
        end
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0000_0000;
        closed = 11'h000;
        glitch = 11'h000;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rd(8'(4 * i), 32'(DEF_CODE[i]), 32'hFFFF_FFFF, "code");
        end
        chk("heat", 32'h1, 32'(heat_mode));
        chk("circuits", 32'h3, 32'(circ_on));
        rd(cifm_pkg::REG_CTRL, 32'h64, 32'hFFFF_FFFF, "ctrl");
        rd(cifm_pkg::REG_SETPT, 32'h0005_2323, 32'hFFFF_FFFF, "setpt");
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, 32'h0, 32'hFFFF_FFFF, "unmapped");
        rd(cifm_pkg::REG_CTRL, 32'h64, 32'hFFFF_FFFF, "ctrl kept");
        wr(8'h08, 32'h12);
        rd(8'h08, 32'h0, 32'hFFFF_FFFF, "code over range");
        wr(cifm_pkg::REG_CTRL, 32'h7F);
        rd(cifm_pkg::REG_STATUS, 32'h33D8, 32'hFFFF_FFFF, "master switches");
        // Each code on input 3, closed then open, one heat/cool code at a time
        for (int c = 0; c < 18; c++) begin
            wr(cifm_pkg::REG_CTRL, 32'h64);
            wr(8'h08, 32'(c));
            set3(1'b1);
            rd(cifm_pkg::REG_STATUS, 32'(EXP_C[c]) | 32'h4_0000, 32'hFFFF_FFFF, "closed");
            chk("sp1", (c == 13 || c == 14) ? 32'h1E : 32'h23, 32'(sp1));
            chk("sp2", (c == 13 || c == 15) ? 32'h1E : 32'h23, 32'(sp2));
            set3(1'b0);
            rd(cifm_pkg::REG_STATUS, (c == 5 || c == 11) ? 32'h3000 : (c == 6 ? 32'h30C0 : 32'h3040),
                32'hFFFF_FFFF, "open");
        end
        chk("boost pulses", 32'h1, 32'(boost_seen));
        rd(cifm_pkg::REG_E1_TOT, 32'h1, 32'hFFFF_FFFF, "meter1 total");
        rd(cifm_pkg::REG_E2_TOT, 32'h1, 32'hFFFF_FFFF, "meter2 total");
        rd(cifm_pkg::REG_E1_INT, 32'h1, 32'hFFFF_FFFF, "meter1 interval");
        wr(cifm_pkg::REG_E1_INT, 32'h0);
        wr(8'h08, 32'h07);
        @(posedge clk_in);
        glitch[2] <= 1'b1;
        @(posedge clk_in);
        glitch[2] <= 1'b0;
        repeat (12) @(posedge clk_in);
        rd(cifm_pkg::REG_E1_INT, 32'h0, 32'hFFFF_FFFF, "bounce");
        set3(1'b1);
        set3(1'b0);
        rd(cifm_pkg::REG_E1_INT, 32'h1, 32'hFFFF_FFFF, "interval");
        rd(cifm_pkg::REG_E1_TOT, 32'h2, 32'hFFFF_FFFF, "total");
        // Force off with every master switch on, stored switches come back after open
        wr(cifm_pkg::REG_CTRL, 32'h7F);
        wr(8'h08, 32'h10);
        set3(1'b1);
        rd(cifm_pkg::REG_STATUS, 32'h4_4340, 32'hFFFF_FFFF, "force off");
        set3(1'b0);
        rd(cifm_pkg::REG_STATUS, 32'h33D8, 32'hFFFF_FFFF, "force off open");
        // Cooling raises the circuit one setpoint
        wr(cifm_pkg::REG_CTRL, 32'h60);
        wr(8'h08, 32'h0E);
        set3(1'b1);
        #1;
        chk("cool sp1", 32'h28, 32'(sp1));
        chk("cool sp2", 32'h23, 32'(sp2));
        set3(1'b0);
        tally_and_finish();
    end
endmodule
